// ---- hdl/hdr_search_pkg.sv ----
// Microword_constant, types and header layout for the disk header search and verify sequencer.
// Assumes one 100 MHz system clock; drive clocks arrive as plain pins.
package hdr_search_pkg;
  localparam int CLK_MHZ = 100;
  localparam int HDR_BITS = 32;
  localparam int CRC_BITS = 16;
  localparam int SYNC_BITS = 8;
  localparam logic [7:0] SYNC_PATTERN = 8'h19;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam int LOCK_SERVO_PULSES = 88;
  localparam int TIMEOUT_MS = 1000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ;
  // Header bit positions, in arrival order
  localparam int HDR_CYL_LO = 0;
  localparam int HDR_CYL_HI = 9;
  localparam int HDR_HEAD_LO = 10;
  localparam int HDR_HEAD_HI = 14;
  localparam int HDR_SECT_LO = 16;
  localparam int HDR_SECT_HI = 20;
  localparam int HDR_SKIP_BIT = 21;
  // Function codes
  localparam logic [2:0] FN_WRITE = 3'h1;
  localparam logic [2:0] FN_READ = 3'h2;
  localparam logic [2:0] FN_WCHECK = 3'h3;

  typedef enum logic [1:0] {
    CLK_CPU = 2'h0,
    CLK_SERVO = 2'h1,
    CLK_READ = 2'h2
  } clk_src_t;

  typedef struct packed {
    logic [9:0] cylinder;
    logic [4:0] head;
    logic [4:0] sector;
  } disk_addr_t;

  typedef struct packed {
    logic skip_sector_error;
    logic operation_incomplete;
    logic controller_done;
    logic timeout_error;
  } search_status_t;

  typedef struct packed {
    logic write_go;
    logic read_go;
    logic check_go;
  } phase_go_t;
endpackage

// ---- hdl/disk_header_search_verify.sv ----
// Header sync search, address compare, skip-sector and header CRC check sequencer.
// Assumes drive read clock/data, servo clock and sector/index pulses are asynchronous pins.
`timescale 1ns/1ps
// Contract
// - Clear shifter, load sync constant, raise read gate
// - Read clock on datapath; microstep waits for sync
// - Sync releases microstep, starts CRC and serializer
// - Mask unused and flag header bits
// - Reorder address bits to header order
// - Compare masked stream with address stream bitwise
// - CRC over all 32 header bits
// - After 32 bits stop serializer, test match
// - Miss: servo clock, await sector pulse, retry
// - Retry per sector until match or timeout
// - Skip error when flag set, not inhibited
// - Skip: set status, bump sector, retry
// - After one skip, stop checking skip flags
// - Load header CRC, compare with computed
// - CRC error: CPU clock, incomplete, done
// - CRC error raises bus request if enabled
// - CRC good: clear CRC, dispatch function
// - Sector pulse from sector or index input
// - Clear CRC, match; wait 88 servo pulses
module disk_header_search_verify #(
  parameter int TIMEOUT_COUNT = hdr_search_pkg::TIMEOUT_CYCLES,
  parameter int LOCK_PULSES = hdr_search_pkg::LOCK_SERVO_PULSES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [2:0] function_code,
  input wire logic skip_sector_check_inhibit,
  input wire logic interrupt_enable,
  input wire hdr_search_pkg::disk_addr_t disk_address_in,
  input wire logic drive_read_clock,
  input wire logic drive_serial_read_stream,
  input wire logic drive_servo_clock,
  input wire logic drive_sector_pulse,
  input wire logic drive_index_pulse,
  output logic read_gate,
  output hdr_search_pkg::clk_src_t datapath_clock_sel,
  output hdr_search_pkg::clk_src_t microstep_clock_sel,
  output logic sync_detected,
  output logic address_match_flag,
  output hdr_search_pkg::disk_addr_t disk_address,
  output hdr_search_pkg::search_status_t status,
  output logic bus_request,
  output hdr_search_pkg::phase_go_t phase_go,
  output logic busy
);
  if (LOCK_PULSES < 1 || LOCK_PULSES > 255 || TIMEOUT_COUNT < 2) begin : g_bad_param
    $error("disk_header_search_verify: unsupported parameter value");
  end

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_WAIT_SECTOR = 8'h02,
    ST_LOCK = 8'h04,
    ST_SYNC = 8'h08,
    ST_HEADER = 8'h10,
    ST_CHECK = 8'h20,
    ST_CRC = 8'h40,
    ST_DISPATCH = 8'h80
  } state_t;

  state_t state_q, state_d;

  // Two-flop synchronisers; stage one feeds only stage two
  logic [4:0] sync1_q, sync2_q;
  logic rclk_prev_q, servo_prev_q, sect_prev_q;
  always_ff @(posedge clk) begin
    sync1_q <= {drive_read_clock, drive_serial_read_stream, drive_servo_clock, drive_sector_pulse, drive_index_pulse};
    sync2_q <= sync1_q;
    rclk_prev_q <= sync2_q[4];
    servo_prev_q <= sync2_q[2];
    sect_prev_q <= sync2_q[1] | sync2_q[0];
  end

  wire rclk_edge = sync2_q[4] & ~rclk_prev_q;
  wire rdata = sync2_q[3];
  wire servo_edge = sync2_q[2] & ~servo_prev_q;
  wire synced_sector_pulse = (sync2_q[1] | sync2_q[0]) & ~sect_prev_q;

  logic [7:0] shift_q;
  logic [7:0] microword_constant_q;
  logic [7:0] lock_cnt_q;
  logic [4:0] bit_cnt_q;
  logic [3:0] crc_cnt_q;
  logic [15:0] crc_q;
  logic skip_flag_q, skip_seen_q, ie_q;
  logic [2:0] fn_q;
  logic [31:0] timer_q;

  // Serializer: address bit that lines up with each header position
  function automatic logic dar_bit(input hdr_search_pkg::disk_addr_t a, input logic [4:0] idx);
    int i;
    i = int'(idx);
    dar_bit = 1'b0;
    if (i >= hdr_search_pkg::HDR_CYL_LO && i <= hdr_search_pkg::HDR_CYL_HI)
      dar_bit = a.cylinder[i - hdr_search_pkg::HDR_CYL_LO];
    else if (i >= hdr_search_pkg::HDR_HEAD_LO && i <= hdr_search_pkg::HDR_HEAD_HI)
      dar_bit = a.head[i - hdr_search_pkg::HDR_HEAD_LO];
    else if (i >= hdr_search_pkg::HDR_SECT_LO && i <= hdr_search_pkg::HDR_SECT_HI)
      dar_bit = a.sector[i - hdr_search_pkg::HDR_SECT_LO];
  endfunction

  // Only address positions survive the mask; flags and unused bits drop out
  function automatic logic addr_pos(input logic [4:0] idx);
    int i;
    i = int'(idx);
    addr_pos = (i >= hdr_search_pkg::HDR_CYL_LO && i <= hdr_search_pkg::HDR_HEAD_HI)
      || (i >= hdr_search_pkg::HDR_SECT_LO && i <= hdr_search_pkg::HDR_SECT_HI);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? hdr_search_pkg::CRC_POLY : 16'h0000);
  endfunction

  wire in_read = (state_q == ST_SYNC) || (state_q == ST_HEADER) || (state_q == ST_CRC);
  wire bit_tick = in_read & rclk_edge;
  wire sync_hit = (state_q == ST_SYNC) && bit_tick && ({shift_q[6:0], rdata} == microword_constant_q);
  wire serialized_address_stream = dar_bit(disk_address, bit_cnt_q);
  wire masked_header_stream = rdata & addr_pos(bit_cnt_q);
  wire masked_address = serialized_address_stream & addr_pos(bit_cnt_q);
  wire bit_differs = masked_header_stream != masked_address;
  wire hdr_last = (state_q == ST_HEADER) && bit_tick && (bit_cnt_q == 5'(hdr_search_pkg::HDR_BITS - 1));
  wire crc_last = (state_q == ST_CRC) && bit_tick && (crc_cnt_q == 4'(hdr_search_pkg::CRC_BITS - 1));
  wire crc_final_ok = crc_step(crc_q, rdata) == 16'h0000;
  wire skip_sector_error = skip_flag_q & ~skip_sector_check_inhibit & ~skip_seen_q;
  wire timed_out = (timer_q == 32'(TIMEOUT_COUNT - 1)) && (state_q != ST_IDLE) && (state_q != ST_DISPATCH);
  wire lock_done = (state_q == ST_LOCK) && servo_edge && (lock_cnt_q == 8'(LOCK_PULSES - 1));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (start) state_d = ST_WAIT_SECTOR;
      ST_WAIT_SECTOR: if (synced_sector_pulse) state_d = ST_LOCK;
      ST_LOCK: if (lock_done) state_d = ST_SYNC;
      ST_SYNC: if (sync_hit) state_d = ST_HEADER;
      ST_HEADER: if (hdr_last) state_d = ST_CHECK;
      ST_CHECK: begin
        if (!address_match_flag || skip_sector_error) state_d = ST_WAIT_SECTOR;
        else state_d = ST_CRC;
      end
      ST_CRC: if (crc_last) state_d = crc_final_ok ? ST_DISPATCH : ST_IDLE;
      ST_DISPATCH: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    if (timed_out) state_d = ST_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rstn) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // Clock control: read clock withheld from microstep until sync
  assign datapath_clock_sel = in_read ? hdr_search_pkg::CLK_READ
    : (state_q == ST_IDLE) ? hdr_search_pkg::CLK_CPU : hdr_search_pkg::CLK_SERVO;
  assign microstep_clock_sel = (in_read && state_q != ST_SYNC) ? hdr_search_pkg::CLK_READ
    : (state_q == ST_IDLE) ? hdr_search_pkg::CLK_CPU : hdr_search_pkg::CLK_SERVO;
  assign read_gate = (state_q == ST_LOCK) || in_read;
  assign sync_detected = (state_q == ST_HEADER) || (state_q == ST_CHECK) || (state_q == ST_CRC);
  assign busy = state_q != ST_IDLE;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      shift_q <= 8'h00;
      microword_constant_q <= 8'h00;
      lock_cnt_q <= 8'h00;
      bit_cnt_q <= 5'h00;
      crc_cnt_q <= 4'h0;
    end else begin
      if (state_q == ST_LOCK) begin
        shift_q <= 8'h00;
        microword_constant_q <= hdr_search_pkg::SYNC_PATTERN;
      end else if (state_q == ST_SYNC && bit_tick) begin
        shift_q <= {shift_q[6:0], rdata};
      end
      if (state_q != ST_LOCK) lock_cnt_q <= 8'h00;
      else if (servo_edge) lock_cnt_q <= lock_cnt_q + 8'h01;
      if (state_q != ST_HEADER) bit_cnt_q <= 5'h00;
      else if (bit_tick) bit_cnt_q <= bit_cnt_q + 5'h01;
      if (state_q != ST_CRC) crc_cnt_q <= 4'h0;
      else if (bit_tick) crc_cnt_q <= crc_cnt_q + 4'h1;
    end
  end

  // CRC runs over header and stored check bits; zero residue means good
  always_ff @(posedge clk) begin
    if (!rstn) crc_q <= hdr_search_pkg::CRC_INIT;
    else if (state_q == ST_LOCK || state_q == ST_DISPATCH) crc_q <= hdr_search_pkg::CRC_INIT;
    else if ((state_q == ST_HEADER || state_q == ST_CRC) && bit_tick) crc_q <= crc_step(crc_q, rdata);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      address_match_flag <= 1'b0;
      skip_flag_q <= 1'b0;
    end else if (state_q == ST_LOCK) begin
      address_match_flag <= 1'b0;
      skip_flag_q <= 1'b0;
    end else if (sync_hit) begin
      address_match_flag <= 1'b1;
    end else if (state_q == ST_HEADER && bit_tick) begin
      if (bit_differs) address_match_flag <= 1'b0;
      if (bit_cnt_q == 5'(hdr_search_pkg::HDR_SKIP_BIT)) skip_flag_q <= rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      disk_address <= '0;
      fn_q <= 3'h0;
      ie_q <= 1'b0;
      skip_seen_q <= 1'b0;
      status <= '0;
      bus_request <= 1'b0;
      timer_q <= 32'h0000_0000;
    end else begin
      if (state_q == ST_IDLE && start) begin
        disk_address <= disk_address_in;
        fn_q <= function_code;
        ie_q <= interrupt_enable;
        skip_seen_q <= 1'b0;
        status <= '0;
        bus_request <= 1'b0;
      end
      if (state_q == ST_CHECK && address_match_flag && skip_sector_error) begin
        status.skip_sector_error <= 1'b1;
        disk_address.sector <= disk_address.sector + 5'h01;
        skip_seen_q <= 1'b1;
      end
      if (crc_last && !crc_final_ok) begin
        status.operation_incomplete <= 1'b1;
        status.controller_done <= 1'b1;
        bus_request <= ie_q;
      end
      if (timed_out) begin
        status.timeout_error <= 1'b1;
        status.controller_done <= 1'b1;
        bus_request <= ie_q;
      end
      if (state_q == ST_IDLE) timer_q <= 32'h0000_0000;
      else if (!timed_out) timer_q <= timer_q + 32'h0000_0001;
    end
  end

  // One-cycle dispatch into the data phase
  assign phase_go.write_go = (state_q == ST_DISPATCH) && (fn_q == hdr_search_pkg::FN_WRITE);
  assign phase_go.read_go = (state_q == ST_DISPATCH) && (fn_q == hdr_search_pkg::FN_READ);
  assign phase_go.check_go = (state_q == ST_DISPATCH) && (fn_q == hdr_search_pkg::FN_WCHECK);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_MICRO_HELD: assert property (state_q == ST_SYNC |-> microstep_clock_sel != hdr_search_pkg::CLK_READ
    && datapath_clock_sel == hdr_search_pkg::CLK_READ) else $error("read clock reached microstep before sync");
  AST_SYNC_LOADED: assert property ($rose(state_q == ST_SYNC) |-> shift_q == 8'h00
    && microword_constant_q == hdr_search_pkg::SYNC_PATTERN) else $error("sync search not preset");
  AST_SYNC_RELEASE: assert property (sync_hit && !timed_out |=> state_q == ST_HEADER
    && microstep_clock_sel == hdr_search_pkg::CLK_READ && bit_cnt_q == 5'h00) else $error("sync did not release");
  AST_HDR_LEN: assert property ($rose(state_q == ST_HEADER) |-> bit_cnt_q == 5'h00 ##1 (state_q != ST_CHECK) [*4])
    else $error("header compare ended early");
  AST_MISS_RETRY: assert property (state_q == ST_CHECK && !address_match_flag && !timed_out |=>
    state_q == ST_WAIT_SECTOR && datapath_clock_sel == hdr_search_pkg::CLK_SERVO && !read_gate)
    else $error("miss did not return to servo clock");
  AST_SKIP_BUMP: assert property (state_q == ST_CHECK && address_match_flag && skip_sector_error |=>
    disk_address.sector == $past(disk_address.sector) + 5'h01 && status.skip_sector_error && skip_seen_q)
    else $error("skip sector not handled");
  AST_CRC_FAIL: assert property (crc_last && !crc_final_ok && !timed_out |=> state_q == ST_IDLE
    && status.operation_incomplete && status.controller_done && datapath_clock_sel == hdr_search_pkg::CLK_CPU)
    else $error("header crc error not reported");
  AST_BR_GATED: assert property ($rose(status.operation_incomplete) |-> bus_request == ie_q)
    else $error("bus request not gated by interrupt enable");
  AST_DISPATCH: assert property (crc_last && crc_final_ok && !timed_out |=> state_q == ST_DISPATCH
    && $onehot0(phase_go) ##1
    (phase_go == '0 && crc_q == hdr_search_pkg::CRC_INIT)) else $error("dispatch malformed");
  // Flag is cleared by the first lock cycle, so it reads low from the next one on
  AST_LOCK_WAIT: assert property ($rose(state_q == ST_LOCK) |=> !address_match_flag [*2])
    else $error("match flag not cleared before lock wait");
  AST_TIMEOUT: assert property (timed_out |=> state_q == ST_IDLE && status.timeout_error && status.controller_done)
    else $error("timeout did not end search");

  COV_MATCH: cover property (state_q == ST_CHECK && address_match_flag && !skip_sector_error);
  COV_MISS: cover property (state_q == ST_CHECK && !address_match_flag);
  COV_SKIP: cover property (state_q == ST_CHECK && address_match_flag && skip_sector_error);
  COV_CRC_BAD: cover property (crc_last && !crc_final_ok);
endmodule // disk_header_search_verify

// ---- verif/drive_model.sv ----
// Behavioural disk drive: servo clock, sector/index pulses, framed read clock and data.
// Assumes the bench calls sector() once per header it wants the sequencer to see.
`timescale 1ns/1ps
module drive_model #(
  parameter realtime HALF = 62.5
) (
  input wire logic read_gate,
  input wire hdr_search_pkg::clk_src_t datapath_clock_sel,
  output logic drive_read_clock,
  output logic drive_serial_read_stream,
  output logic drive_servo_clock,
  output logic drive_sector_pulse,
  output logic drive_index_pulse
);
  initial begin
    drive_read_clock = 1'b0;
    drive_serial_read_stream = 1'b0;
    drive_servo_clock = 1'b0;
    drive_sector_pulse = 1'b0;
    drive_index_pulse = 1'b0;
  end

  // Servo track runs free, read clock only inside a frame
  always #(HALF) drive_servo_clock = ~drive_servo_clock;

  task automatic sector(input logic [31:0] hdr, input logic bad_crc, input logic idx);
    logic [15:0] crc;
    logic [63:0] frame;
    int n;
    crc = 16'hFFFF;
    for (int i = 0; i < 32; i++) begin
      crc = {crc[14:0], 1'b0} ^ (((crc[15] ^ hdr[i]) == 1'b1) ? 16'h1021 : 16'h0000);
    end
    crc[0] = crc[0] ^ bad_crc;
    frame = {8'h00, 8'h19, 32'h0000_0000, crc};
    for (int i = 0; i < 32; i++) begin
      frame[47 - i] = hdr[i];
    end
    // Gap so the pulse never lands before the sequencer waits for it
    #2000;
    if (idx) drive_index_pulse = 1'b1;
    else drive_sector_pulse = 1'b1;
    #300;
    drive_index_pulse = 1'b0;
    drive_sector_pulse = 1'b0;
    for (n = 0; n < 5000 && datapath_clock_sel !== hdr_search_pkg::CLK_READ; n++) #10;
    if (n < 5000) begin
      for (int i = 63; i >= 0; i--) begin
        drive_serial_read_stream = frame[i];
        #(HALF) drive_read_clock = 1'b1;
        #(HALF) drive_read_clock = 1'b0;
      end
      // Released line must not hold its last bit
      drive_serial_read_stream = ~frame[0];
    end
  endtask
endmodule // drive_model

// ---- verif/disk_header_search_verify_tb_top.sv ----
// Self-checking bench for the header search and verify sequencer.
// Assumes drive_model on the drive pins and a shortened timeout parameter.
`timescale 1ns/1ps
module disk_header_search_verify_tb_top;
  localparam int TO = 20000;
  localparam hdr_search_pkg::disk_addr_t A = {10'h2A5, 5'h13, 5'h0A};
  logic clk, rstn, start, skip_sector_check_inhibit, interrupt_enable, read_gate, sync_detected;
  logic address_match_flag, bus_request, busy, drc, dsd, dsc, dsp, dip;
  logic saw_stall, saw_run, saw_retry;
  logic [2:0] function_code;
  hdr_search_pkg::disk_addr_t disk_address_in, disk_address;
  hdr_search_pkg::clk_src_t datapath_clock_sel, microstep_clock_sel;
  hdr_search_pkg::search_status_t status;
  hdr_search_pkg::phase_go_t phase_go, go_seen;
  int err_total = 0;
  int cmp_count = 0;

  disk_header_search_verify #(.TIMEOUT_COUNT(TO), .LOCK_PULSES(8)) i_dut (.clk(clk), .rstn(rstn), .start(start),
    .function_code(function_code), .skip_sector_check_inhibit(skip_sector_check_inhibit),
    .interrupt_enable(interrupt_enable), .disk_address_in(disk_address_in), .drive_read_clock(drc),
    .drive_serial_read_stream(dsd), .drive_servo_clock(dsc), .drive_sector_pulse(dsp), .drive_index_pulse(dip),
    .read_gate(read_gate), .datapath_clock_sel(datapath_clock_sel), .microstep_clock_sel(microstep_clock_sel),
    .sync_detected(sync_detected), .address_match_flag(address_match_flag), .disk_address(disk_address),
    .status(status), .bus_request(bus_request), .phase_go(phase_go), .busy(busy));
  drive_model i_drv (.read_gate(read_gate), .datapath_clock_sel(datapath_clock_sel), .drive_read_clock(drc),
    .drive_serial_read_stream(dsd), .drive_servo_clock(dsc), .drive_sector_pulse(dsp), .drive_index_pulse(dip));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("ADDRESS_MATCH_FLAG %0t %s", $time, msg);
    end
  endtask

  // Unused positions carry ones so an unmasked compare would miss
  function automatic logic [31:0] hdr(input hdr_search_pkg::disk_addr_t a, input logic skip);
    hdr = 32'hFFC0_8000;
    hdr[9:0] = a.cylinder;
    hdr[14:10] = a.head;
    hdr[20:16] = a.sector;
    hdr[21] = skip;
  endfunction

  task automatic launch(input logic [2:0] fc, input logic ie, input logic inh);
    @(negedge clk);
    function_code = fc;
    interrupt_enable = ie;
    skip_sector_check_inhibit = inh;
    disk_address_in = A;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask

  task automatic watch();
    int n;
    go_seen = '0;
    saw_stall = 1'b0;
    saw_run = 1'b0;
    saw_retry = 1'b0;
    for (n = 0; n < 30000 && !(n > 2 && busy === 1'b0); n++) begin
      @(negedge clk);
      go_seen = go_seen | phase_go;
      if (datapath_clock_sel === hdr_search_pkg::CLK_READ && microstep_clock_sel === hdr_search_pkg::CLK_SERVO)
        saw_stall = 1'b1;
      if (sync_detected === 1'b1 && microstep_clock_sel === hdr_search_pkg::CLK_READ) saw_run = 1'b1;
      if (saw_run && busy === 1'b1 && read_gate === 1'b0 && datapath_clock_sel === hdr_search_pkg::CLK_SERVO &&
          microstep_clock_sel === hdr_search_pkg::CLK_SERVO) saw_retry = 1'b1;
    end
    if (busy !== 1'b0) begin
      err_total++;
      $display("ADDRESS_MATCH_FLAG %0t sequencer hung", $time);
      results();
    end
  endtask

  task automatic finish_chk(input logic [2:0] go, input logic [3:0] st, input logic br,
                            input hdr_search_pkg::disk_addr_t a);
    chk(go_seen === go, "dispatch pulse");
    chk(status === st, "status bits");
    chk(bus_request === br, "bus request");
    chk(disk_address === a, "disk address");
    chk(datapath_clock_sel === hdr_search_pkg::CLK_CPU && microstep_clock_sel === hdr_search_pkg::CLK_CPU,
        "clock back to cpu");
  endtask

  task automatic s_crc_error();
    for (int ie = 0; ie < 2; ie++) begin
      launch(3'h2, ie[0], 1'b0);
      fork
        watch();
        i_drv.sector(hdr(A, 1'b0), 1'b1, 1'b0);
      join
      finish_chk(3'b000, 4'b0110, ie[0], A);
    end
  endtask

  task automatic s_good();
    for (int fc = 1; fc < 4; fc++) begin
      launch(fc[2:0], 1'b0, 1'b0);
      fork
        watch();
        i_drv.sector(hdr(A, 1'b0), 1'b0, 1'b0);
      join
      chk(saw_stall, "read clock held off microstep");
      chk(saw_run, "microstep runs after sync");
      chk(address_match_flag === 1'b1, "match flag");
      finish_chk(3'b100 >> (fc - 1), 4'b0000, 1'b0, A);
    end
  endtask

  task automatic s_miss();
    hdr_search_pkg::disk_addr_t c, h, s;
    c = A;
    c.cylinder[9] = ~c.cylinder[9];
    h = A;
    h.head[0] = ~h.head[0];
    s = A;
    s.sector[4] = ~s.sector[4];
    launch(3'h2, 1'b1, 1'b0);
    fork
      watch();
      begin
        i_drv.sector(hdr(c, 1'b0), 1'b0, 1'b0);
        i_drv.sector(hdr(h, 1'b0), 1'b0, 1'b0);
        i_drv.sector(hdr(s, 1'b0), 1'b0, 1'b0);
        i_drv.sector(hdr(A, 1'b0), 1'b0, 1'b1);
      end
    join
    chk(saw_retry, "servo clock while waiting");
    finish_chk(3'b010, 4'b0000, 1'b0, A);
  endtask

  task automatic s_skip(input logic inh);
    hdr_search_pkg::disk_addr_t n;
    n = A;
    n.sector = n.sector + 5'h01;
    launch(inh ? 3'h1 : 3'h3, 1'b0, inh);
    fork
      watch();
      begin
        i_drv.sector(hdr(A, 1'b1), 1'b0, 1'b0);
        if (!inh) i_drv.sector(hdr(n, 1'b1), 1'b0, 1'b0);
      end
    join
    if (inh) finish_chk(3'b100, 4'b0000, 1'b0, A);
    else finish_chk(3'b001, 4'b1000, 1'b0, n);
  endtask

  task automatic s_timeout();
    launch(3'h2, 1'b1, 1'b0);
    watch();
    finish_chk(3'b000, 4'b0011, 1'b1, A);
  endtask

  initial begin
    rstn = 1'b0;
    start = 1'b0;
    function_code = 3'h0;
    skip_sector_check_inhibit = 1'b0;
    interrupt_enable = 1'b0;
    disk_address_in = '0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk(busy === 1'b0 && status === 4'b0000 && bus_request === 1'b0, "reset state");
    s_crc_error();
    s_good();
    s_miss();
    s_skip(1'b0);
    s_skip(1'b1);
    s_timeout();
    results();
  end
endmodule // disk_header_search_verify_tb_top
